// ### logic/video_level_params.svh
/*
  Constants of the video level and component path: register offsets,
  reset values and fixed arithmetic figures.
  Assumes inclusion by bare name from the design file and the testbench.
*/
`ifndef VIDEO_LEVEL_PARAMS_SVH
`define VIDEO_LEVEL_PARAMS_SVH

// Register byte offsets
`define VL_OFS_LUMA_CON 8'h00
`define VL_OFS_LUMA_BRI 8'h01
`define VL_OFS_CHR_SAT 8'h02
`define VL_OFS_RAW_GAIN 8'h03
`define VL_OFS_RAW_OFS 8'h04
`define VL_OFS_CMP_CON 8'h05
`define VL_OFS_CMP_BRI 8'h06
`define VL_OFS_CMP_SAT 8'h07
`define VL_OFS_STATUS 8'h08
`define VL_OFS_CTRL 8'h29

// Control register fields
`define VL_CTRL_HP_BIT 0
`define VL_CTRL_BYP_BIT 1
`define VL_CTRL_RST 8'h00

// Level stage reset values
`define VL_CON_RST 8'h44
`define VL_BRI_RST 8'h80
`define VL_SAT_RST 8'h40
`define VL_RAW_GAIN_RST 8'h40
`define VL_RAW_OFS_RST 8'h80

// Level arithmetic
`define VL_MID 10'sh080
`define VL_LUMA_DIV 19'sh0_0044
`define VL_SAT_DIV 19'sh0_0040
`define VL_LIM_MIN 20'sh0_0001
`define VL_LIM_MAX 20'sh0_00FE

// Matrix coefficients, scaled by 1024 (luma weights sum to 1024)
`define VL_KR 11'h132
`define VL_KG 11'h259
`define VL_KB 11'h075
`define VL_KCB 12'sh24F
`define VL_KCR 12'sh2EB
`define VL_MAT_SHIFT 10
`define VL_C9_MID 12'sh100
`define VL_C9_MAX 12'sh1FF

// High-pass boost shift: 1 + 4/16 at half the sample rate
`define VL_HP_SHIFT 4

`endif

// ### logic/video_level_pkg.sv
/*
  Types shared by the video level and component path.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package video_level_pkg;

  // Chroma slot phase, one-hot
  typedef enum logic [1:0] {
    PH_CB = 2'b01,
    PH_CR = 2'b10
  } slot_phase_e;

endpackage : video_level_pkg

// ### logic/video_level_and_component_path.sv
/*
  Decoder level stage, raw composite level stage, colour matrix with
  bypass, downformatter with luma high-pass and component level stage.
  Assumes every sample input is on CORE_CLK and is qualified by the
  one-cycle sample enable SMP_EN from the line-locked rate divider.
*/
// Chosen here: the placing of the registers and the strobed register port.
// Functional notes
// RQ1: Luma out = contrast/68*(Y-128) plus brightness
// RQ2: Chroma out = saturation/64*(C-128) plus 128
// RQ3: Decoder defaults 44h, 80h, 40h after reset
// RQ4: Raw out = gain/64*(sample-128) plus offset
// RQ5: Raw gain defaults 64, offset 128
// RQ6: All level results limited to 1..254
// RQ7: Matrix 9-bit in and out, unity gain
// RQ8: Matrix uses the standard luma/difference weights
// RQ9: Bypass path has matrix latency
// RQ10: Colour differences low-pass filtered before decimation
// RQ11: Red difference delayed one clock extra
// RQ12: Phase zero slot carries blue difference
// RQ13: Chroma output registered, mux runs opposite
// RQ14: Luma high-pass, 2 dB boost, unity DC
// RQ15: High-pass output clipped to 0..511
// RQ16: One control bit switches high-pass
// RQ17: Component luma has own contrast, brightness
// RQ18: Component chroma has own saturation
// RQ19: Component stage same equations and defaults
// RQ20: Truncate product toward zero, then limit
// RQ21: One sample per enable, hold otherwise
`include "video_level_params.svh"

module video_level_and_component_path (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Sample enable
  input wire logic SMP_EN,
  // Decoder samples
  input wire logic [7:0] DEC_Y_IN,
  input wire logic [7:0] DEC_CB_IN,
  input wire logic [7:0] DEC_CR_IN,
  input wire logic [7:0] RAW_IN,
  // Component samples (R/G/B or Cr/Y/Cb in bypass)
  input wire logic [8:0] CMP_R_IN,
  input wire logic [8:0] CMP_G_IN,
  input wire logic [8:0] CMP_B_IN,
  // Decoder results
  output logic [7:0] DEC_Y,
  output logic [7:0] DEC_CB,
  output logic [7:0] DEC_CR,
  output logic [7:0] RAW_OUT,
  // Component results
  output logic [7:0] CMP_Y,
  output logic [7:0] CMP_C,
  output logic CMP_PHASE
);

  // Shared level equation, with either divisor
  function automatic logic [7:0] level_calc(input logic [7:0] x, input logic [7:0] gain,
                                            input logic [7:0] ofs, input logic luma);
    logic signed [9:0] d;
    logic signed [18:0] p;
    logic signed [18:0] q;
    logic signed [19:0] s;
    d = $signed({2'b00, x}) - `VL_MID;
    p = $signed({1'b0, gain}) * d;
    // Signed division truncates toward zero before the offset goes in
    q = luma ? (p / `VL_LUMA_DIV) : (p / `VL_SAT_DIV); // RQ20
    s = 20'(q) + $signed({12'h000, ofs});
    if (s < `VL_LIM_MIN) begin // RQ6
      level_calc = 8'(`VL_LIM_MIN);
    end else if (s > `VL_LIM_MAX) begin
      level_calc = 8'(`VL_LIM_MAX);
    end else begin
      level_calc = s[7:0];
    end
  endfunction : level_calc

  // Clip a signed intermediate into the 9-bit range
  function automatic logic [8:0] clip9(input logic signed [11:0] v);
    if (v < 12'sh000) begin
      clip9 = 9'h000;
    end else if (v > `VL_C9_MAX) begin
      clip9 = 9'h1FF;
    end else begin
      clip9 = v[8:0];
    end
  endfunction : clip9

  // Colour difference from a 9-bit primary and luma
  function automatic logic [8:0] diff9(input logic [8:0] p, input logic [8:0] y,
                                       input logic signed [11:0] k);
    logic signed [9:0] d;
    logic signed [21:0] m;
    d = $signed({1'b0, p}) - $signed({1'b0, y});
    m = 22'(d * k) >>> `VL_MAT_SHIFT;
    diff9 = clip9(12'(m) + `VL_C9_MID);
  endfunction : diff9

  // Software registers
  logic [7:0] luma_contrast_gain;
  logic [7:0] luma_brightness_offset;
  logic [7:0] chroma_saturation_gain;
  logic [7:0] raw_composite_gain;
  logic [7:0] raw_composite_offset;
  logic [7:0] component_contrast_gain;
  logic [7:0] component_brightness_offset;
  logic [7:0] component_saturation_gain;
  logic [7:0] ctrl;
  logic [7:0] next_luma_contrast_gain;
  logic [7:0] next_luma_brightness_offset;
  logic [7:0] next_chroma_saturation_gain;
  logic [7:0] next_raw_composite_gain;
  logic [7:0] next_raw_composite_offset;
  logic [7:0] next_component_contrast_gain;
  logic [7:0] next_component_brightness_offset;
  logic [7:0] next_component_saturation_gain;
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  logic [7:0] status; // Live view of the block's own state
  logic component_highpass_enable; // Switches the whole luma high-pass
  logic comp_bypass; // Inputs are already Y/Cb/Cr
  logic hp_clipped; // Last high-pass result hit a limit

  assign component_highpass_enable = ctrl[`VL_CTRL_HP_BIT];
  assign comp_bypass = ctrl[`VL_CTRL_BYP_BIT];
  assign status = {5'h00, hp_clipped, comp_bypass, CMP_PHASE};

  // Register writes and read data
  always_comb begin
    next_luma_contrast_gain = luma_contrast_gain;
    next_luma_brightness_offset = luma_brightness_offset;
    next_chroma_saturation_gain = chroma_saturation_gain;
    next_raw_composite_gain = raw_composite_gain;
    next_raw_composite_offset = raw_composite_offset;
    next_component_contrast_gain = component_contrast_gain;
    next_component_brightness_offset = component_brightness_offset;
    next_component_saturation_gain = component_saturation_gain;
    next_ctrl = ctrl;
    next_rdata = 8'h00; // Unmapped or idle reads return zero
    if (REG_WR) begin
      case (REG_ADDR)
        `VL_OFS_LUMA_CON: next_luma_contrast_gain = REG_WDATA;
        `VL_OFS_LUMA_BRI: next_luma_brightness_offset = REG_WDATA;
        `VL_OFS_CHR_SAT: next_chroma_saturation_gain = REG_WDATA;
        `VL_OFS_RAW_GAIN: next_raw_composite_gain = REG_WDATA;
        `VL_OFS_RAW_OFS: next_raw_composite_offset = REG_WDATA;
        `VL_OFS_CMP_CON: next_component_contrast_gain = REG_WDATA; // RQ17
        `VL_OFS_CMP_BRI: next_component_brightness_offset = REG_WDATA; // RQ17
        `VL_OFS_CMP_SAT: next_component_saturation_gain = REG_WDATA; // RQ18
        `VL_OFS_CTRL: next_ctrl = {6'h00, REG_WDATA[1:0]}; // RQ16
        default: begin
        end
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        `VL_OFS_LUMA_CON: next_rdata = luma_contrast_gain;
        `VL_OFS_LUMA_BRI: next_rdata = luma_brightness_offset;
        `VL_OFS_CHR_SAT: next_rdata = chroma_saturation_gain;
        `VL_OFS_RAW_GAIN: next_rdata = raw_composite_gain;
        `VL_OFS_RAW_OFS: next_rdata = raw_composite_offset;
        `VL_OFS_CMP_CON: next_rdata = component_contrast_gain;
        `VL_OFS_CMP_BRI: next_rdata = component_brightness_offset;
        `VL_OFS_CMP_SAT: next_rdata = component_saturation_gain;
        `VL_OFS_STATUS: next_rdata = status;
        `VL_OFS_CTRL: next_rdata = ctrl;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Register storage; reset values give nominal video levels
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      luma_contrast_gain <= `VL_CON_RST; // RQ3
      luma_brightness_offset <= `VL_BRI_RST; // RQ3
      chroma_saturation_gain <= `VL_SAT_RST; // RQ3
      raw_composite_gain <= `VL_RAW_GAIN_RST; // RQ5
      raw_composite_offset <= `VL_RAW_OFS_RST; // RQ5
      component_contrast_gain <= `VL_CON_RST; // RQ19
      component_brightness_offset <= `VL_BRI_RST; // RQ19
      component_saturation_gain <= `VL_SAT_RST; // RQ19
      ctrl <= `VL_CTRL_RST;
      REG_RDATA <= 8'h00;
    end else begin
      luma_contrast_gain <= next_luma_contrast_gain;
      luma_brightness_offset <= next_luma_brightness_offset;
      chroma_saturation_gain <= next_chroma_saturation_gain;
      raw_composite_gain <= next_raw_composite_gain;
      raw_composite_offset <= next_raw_composite_offset;
      component_contrast_gain <= next_component_contrast_gain;
      component_brightness_offset <= next_component_brightness_offset;
      component_saturation_gain <= next_component_saturation_gain;
      ctrl <= next_ctrl;
      REG_RDATA <= next_rdata;
    end
  end

  // Datapath pipeline state
  logic [8:0] m1_y; // Matrix stage 1: luma
  logic [8:0] m1_r;
  logic [8:0] m1_g;
  logic [8:0] m1_b;
  logic m1_byp; // Bypass choice travels with its sample
  logic [8:0] m2_y; // Matrix output (or bypassed input)
  logic [8:0] m2_cb;
  logic [8:0] m2_cr;
  logic [8:0] cb_t0; // Filter taps
  logic [8:0] cb_t1;
  logic [8:0] cr_t0;
  logic [8:0] cr_t1;
  logic [8:0] cr_dly; // Extra clock on red difference
  logic [8:0] y_t0;
  logic [8:0] y_t1;
  video_level_pkg::slot_phase_e ph; // Multiplexer phase
  logic [8:0] next_m1_y;
  logic [8:0] next_m2_y;
  logic [8:0] next_m2_cb;
  logic [8:0] next_m2_cr;
  logic [8:0] lpf_cb;
  logic [8:0] lpf_cr;
  logic [8:0] hp_y;
  logic next_hp_clipped;
  logic [8:0] mux_c;
  video_level_pkg::slot_phase_e next_ph;
  logic [19:0] y_acc;
  logic signed [11:0] hp_s;
  logic [10:0] cb_sum;
  logic [10:0] cr_sum;

  // Matrix, filters, high-pass clip and multiplexer
  always_comb begin
    // Weighted luma; the weights sum to one, so gain is unity
    y_acc = 20'(`VL_KR * CMP_R_IN) + 20'(`VL_KG * CMP_G_IN) + 20'(`VL_KB * CMP_B_IN); // RQ8
    next_m1_y = y_acc[18:10]; // RQ7
    // Bypass keeps the same two registers, so latency matches
    if (m1_byp) begin // RQ9
      next_m2_y = m1_g;
      next_m2_cb = m1_b;
      next_m2_cr = m1_r;
    end else begin
      next_m2_y = m1_y;
      next_m2_cb = diff9(m1_b, m1_y, `VL_KCB); // RQ8
      next_m2_cr = diff9(m1_r, m1_y, `VL_KCR); // RQ8
    end
    // 1-2-1 low-pass against aliasing at half rate
    cb_sum = 11'(m2_cb) + 11'({cb_t0, 1'b0}) + 11'(cb_t1); // RQ10
    cr_sum = 11'(m2_cr) + 11'({cr_t0, 1'b0}) + 11'(cr_t1); // RQ10
    lpf_cb = cb_sum[10:2];
    lpf_cr = cr_sum[10:2];
    // High-pass on the luma delay taps, centred like the low-pass
    hp_s = $signed({3'b000, y_t0}) + ((($signed({3'b000, y_t0}) <<< 1)
           - $signed({3'b000, m2_y}) - $signed({3'b000, y_t1})) >>> `VL_HP_SHIFT); // RQ14
    hp_y = clip9(hp_s); // RQ15
    next_hp_clipped = hp_s < 12'sh000 || hp_s > `VL_C9_MAX;
    if (!component_highpass_enable) begin // RQ16
      hp_y = y_t0;
      next_hp_clipped = 1'b0;
    end
    // Selection is one phase ahead of the registered slot
    next_ph = (ph == video_level_pkg::PH_CB) ? video_level_pkg::PH_CR
                                             : video_level_pkg::PH_CB;
    case (ph)
      video_level_pkg::PH_CR: mux_c = lpf_cb; // RQ13
      video_level_pkg::PH_CB: mux_c = cr_dly; // RQ11
      default: mux_c = lpf_cb;
    endcase
  end

  // Pipeline registers; everything holds between sample enables
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      m1_y <= 9'h000;
      m1_r <= 9'h000;
      m1_g <= 9'h000;
      m1_b <= 9'h000;
      m1_byp <= 1'b0;
      m2_y <= 9'h000;
      m2_cb <= 9'h100;
      m2_cr <= 9'h100;
      cb_t0 <= 9'h100;
      cb_t1 <= 9'h100;
      cr_t0 <= 9'h100;
      cr_t1 <= 9'h100;
      cr_dly <= 9'h100;
      y_t0 <= 9'h000;
      y_t1 <= 9'h000;
      ph <= video_level_pkg::PH_CB;
      hp_clipped <= 1'b0;
      DEC_Y <= `VL_BRI_RST;
      DEC_CB <= `VL_BRI_RST;
      DEC_CR <= `VL_BRI_RST;
      RAW_OUT <= `VL_BRI_RST;
      CMP_Y <= `VL_BRI_RST;
      CMP_C <= `VL_BRI_RST;
      CMP_PHASE <= 1'b0;
    end else if (SMP_EN) begin // RQ21
      DEC_Y <= level_calc(DEC_Y_IN, luma_contrast_gain, luma_brightness_offset, 1'b1); // RQ1
      DEC_CB <= level_calc(DEC_CB_IN, chroma_saturation_gain, `VL_BRI_RST, 1'b0); // RQ2
      DEC_CR <= level_calc(DEC_CR_IN, chroma_saturation_gain, `VL_BRI_RST, 1'b0); // RQ2
      RAW_OUT <= level_calc(RAW_IN, raw_composite_gain, raw_composite_offset, 1'b0); // RQ4
      m1_y <= next_m1_y;
      m1_r <= CMP_R_IN;
      m1_g <= CMP_G_IN;
      m1_b <= CMP_B_IN;
      m1_byp <= comp_bypass;
      m2_y <= next_m2_y;
      m2_cb <= next_m2_cb;
      m2_cr <= next_m2_cr;
      cb_t0 <= m2_cb;
      cb_t1 <= cb_t0;
      cr_t0 <= m2_cr;
      cr_t1 <= cr_t0;
      cr_dly <= lpf_cr; // RQ11
      y_t0 <= m2_y;
      y_t1 <= y_t0;
      ph <= next_ph;
      hp_clipped <= next_hp_clipped;
      // Component stage takes the upper eight bits of each 9-bit sample
      CMP_Y <= level_calc(hp_y[8:1], component_contrast_gain,
                          component_brightness_offset, 1'b1); // RQ17
      CMP_C <= level_calc(mux_c[8:1], component_saturation_gain, `VL_BRI_RST, 1'b0); // RQ18
      CMP_PHASE <= (ph == video_level_pkg::PH_CR) ? 1'b0 : 1'b1; // RQ12
    end
  end

  // Checks
  default clocking cb_chk @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_byp_two;
    SMP_EN && comp_bypass ##1 SMP_EN;
  endsequence

  sequence s_unity_luma;
    SMP_EN && DEC_Y_IN == 8'h80 && luma_contrast_gain == `VL_CON_RST
      && luma_brightness_offset == `VL_BRI_RST;
  endsequence

  reset_defaults_a: assert property ($rose(RST_N) |-> luma_contrast_gain == `VL_CON_RST // RQ3
    && luma_brightness_offset == `VL_BRI_RST && chroma_saturation_gain == `VL_SAT_RST
    && raw_composite_gain == `VL_RAW_GAIN_RST && raw_composite_offset == `VL_RAW_OFS_RST)
    else $error("level registers not at defaults after reset");
  luma_nominal_a: assert property (s_unity_luma |=> DEC_Y == 8'h80) // RQ1
    else $error("nominal luma not preserved");
  chroma_mid_a: assert property (SMP_EN && DEC_CB_IN == 8'h80 |=> DEC_CB == 8'h80) // RQ2
    else $error("chroma midpoint moved");
  raw_unity_a: assert property (SMP_EN && raw_composite_gain == `VL_RAW_GAIN_RST // RQ4
    && raw_composite_offset == `VL_RAW_OFS_RST && RAW_IN != 8'h00 && RAW_IN != 8'hFF
    |=> RAW_OUT == $past(RAW_IN)) else $error("raw path not unity at defaults");
  level_range_a: assert property (DEC_Y >= 8'h01 && DEC_Y <= 8'hFE && RAW_OUT >= 8'h01 // RQ6
    && RAW_OUT <= 8'hFE && CMP_C >= 8'h01 && CMP_C <= 8'hFE)
    else $error("level result outside 1..254");
  bypass_delay_a: assert property (s_byp_two |=> m2_y == $past(CMP_G_IN, 2)) // RQ9
    else $error("bypass latency mismatch");
  // Samples spaced by one idle cycle must keep the same two-enable latency
  sequence s_byp_gap;
    SMP_EN && comp_bypass ##1 !SMP_EN ##1 SMP_EN;
  endsequence
  bypass_gap_a: assert property (s_byp_gap |=> m2_y == $past(CMP_G_IN, 3)) // RQ9
    else $error("bypass latency mismatch with idle cycles");
  phase_toggle_a: assert property (SMP_EN |=> CMP_PHASE != $past(CMP_PHASE)) // RQ12
    else $error("chroma slot phase did not alternate");
  hold_state_a: assert property (!SMP_EN |=> $stable(DEC_Y) && $stable(CMP_Y) // RQ21
    && $stable(CMP_C)) else $error("pipeline moved without enable");
  hp_off_a: assert property (!component_highpass_enable |-> hp_y == y_t0) // RQ16
    else $error("high-pass active while switched off");

endmodule : video_level_and_component_path

// ### verif/video_sink.sv
/*
  Far-side model of the component chroma stream, standing in for the
  scaler and slicer inputs. It splits the interleaved chroma by phase.
  Assumes it shares the core clock and the sample enable with the block.
*/
module video_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stream from the block
  input wire logic smp_en,
  input wire logic [7:0] chroma,
  input wire logic phase,
  // Last value seen in each slot
  output logic [7:0] cb_seen,
  output logic [7:0] cr_seen
);
  // Enable delayed one cycle: outputs land one edge after the enable
  logic take;

  // Capture on the cycle after each enable, sorted by slot phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      take <= 1'b0;
      cb_seen <= 8'h00;
      cr_seen <= 8'h00;
    end else begin
      take <= smp_en;
      // Phase zero is the first clock of a slot and carries blue difference
      if (take && !phase) begin
        cb_seen <= chroma;
      end else if (take) begin
        cr_seen <= chroma;
      end
    end
  end
endmodule : video_sink

// ### verif/tb.sv
/*
  Self-checking bench for the video level and component path.
  Assumes the design, its package and its header are compiled first.
*/
`include "video_level_params.svh"

// Compare expected against seen and count both outcomes
`define CHK(nm, ex, got) begin samples_checked++; if ((ex) !== (got)) begin \
  $display("ERROR %s expected %h seen %h", nm, ex, got); err_count++; end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and tallies
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b0;
  int err_count = 0;
  int samples_checked = 0;
  // Register port
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  // Sample inputs
  logic SMP_EN = 1'b0;
  logic [7:0] DEC_Y_IN = 8'h80;
  logic [7:0] DEC_CB_IN = 8'h80;
  logic [7:0] DEC_CR_IN = 8'h80;
  logic [7:0] RAW_IN = 8'h80;
  logic [8:0] CMP_R_IN = 9'h100;
  logic [8:0] CMP_G_IN = 9'h100;
  logic [8:0] CMP_B_IN = 9'h100;
  // Results
  logic [7:0] DEC_Y, DEC_CB, DEC_CR, RAW_OUT, CMP_Y, CMP_C;
  logic CMP_PHASE;
  logic [7:0] cb_seen, cr_seen;

  // 40 ns period
  always #20 CORE_CLK = ~CORE_CLK;

  video_level_and_component_path video_level_and_component_path_inst (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SMP_EN(SMP_EN),
    .DEC_Y_IN(DEC_Y_IN), .DEC_CB_IN(DEC_CB_IN), .DEC_CR_IN(DEC_CR_IN), .RAW_IN(RAW_IN),
    .CMP_R_IN(CMP_R_IN), .CMP_G_IN(CMP_G_IN), .CMP_B_IN(CMP_B_IN), .DEC_Y(DEC_Y),
    .DEC_CB(DEC_CB), .DEC_CR(DEC_CR), .RAW_OUT(RAW_OUT), .CMP_Y(CMP_Y), .CMP_C(CMP_C),
    .CMP_PHASE(CMP_PHASE));

  video_sink video_sink_inst (
    .clk(CORE_CLK), .rst_n(RST_N), .smp_en(SMP_EN), .chroma(CMP_C), .phase(CMP_PHASE),
    .cb_seen(cb_seen), .cr_seen(cr_seen));

  // Level equation: integer division truncates toward zero, then limits
  function automatic logic [7:0] lvl(input int g, input int x, input int dv, input int o);
    int r;
    r = (g * (x - 128)) / dv + o;
    if (r < 1) r = 1;
    if (r > 254) r = 254;
    return r[7:0];
  endfunction : lvl

  // One-cycle write strobe
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask : reg_wr

  // One-cycle read strobe; data stands only in the following cycle
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask : reg_rd

  // One sample offered; outputs are read once the enable edge has landed
  task automatic smp(input logic [7:0] y, input logic [7:0] c, input logic [8:0] r,
                     input logic [8:0] g, input logic [8:0] b);
    @(posedge CORE_CLK);
    DEC_Y_IN <= y;
    DEC_CB_IN <= c;
    DEC_CR_IN <= ~c;
    RAW_IN <= y;
    CMP_R_IN <= r;
    CMP_G_IN <= g;
    CMP_B_IN <= b;
    SMP_EN <= 1'b1;
    @(posedge CORE_CLK);
    SMP_EN <= 1'b0;
    #1;
  endtask : smp

  // Reset values, an unmapped read and the control bits that exist
  task automatic check_defaults;
    logic [7:0] ex [9];
    logic [7:0] d;
    ex = '{`VL_CON_RST, `VL_BRI_RST, `VL_SAT_RST, 8'h40, 8'h80, `VL_CON_RST,
           `VL_BRI_RST, `VL_SAT_RST, `VL_CTRL_RST};
    for (int i = 0; i < 9; i++) begin
      reg_rd((i == 8) ? `VL_OFS_CTRL : i[7:0], d);
      `CHK("reset value", ex[i], d)
    end
    reg_rd(`VL_OFS_STATUS, d);
    `CHK("status after reset", 8'h00, d)
    reg_rd(8'h10, d);
    `CHK("unmapped read", 8'h00, d)
    reg_wr(`VL_OFS_CTRL, 8'hFF);
    reg_rd(`VL_OFS_CTRL, d);
    `CHK("control bits", 8'h03, d)
    reg_wr(`VL_OFS_CTRL, 8'h00);
  endtask : check_defaults

  // Decoder and raw stages over several settings, with limits and truncation
  task automatic dec_levels;
    logic [7:0] st [4][5];
    logic [7:0] xs [4];
    st = '{'{8'h44, 8'h80, 8'h40, 8'h40, 8'h80}, '{8'hFF, 8'h10, 8'hFF, 8'hFF, 8'hF0},
           '{8'h22, 8'hC0, 8'h20, 8'h20, 8'h30}, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00}};
    xs = '{8'h00, 8'h7F, 8'h81, 8'hFF};
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 5; k++) begin
        reg_wr(`VL_OFS_LUMA_CON + k[7:0], st[s][k]);
      end
      for (int i = 0; i < 4; i++) begin
        smp(xs[i], xs[i], 9'h100, 9'h100, 9'h100);
        `CHK("luma", lvl(st[s][0], xs[i], 68, st[s][1]), DEC_Y)
        `CHK("blue diff", lvl(st[s][2], xs[i], 64, 128), DEC_CB)
        `CHK("red diff", lvl(st[s][2], 255 - xs[i], 64, 128), DEC_CR)
        `CHK("raw", lvl(st[s][3], xs[i], 64, st[s][4]), RAW_OUT)
      end
    end
  endtask : dec_levels

  // Without an enable the outputs keep their value
  task automatic hold_check;
    logic [7:0] y0;
    logic [7:0] r0;
    y0 = DEC_Y;
    r0 = RAW_OUT;
    @(posedge CORE_CLK);
    DEC_Y_IN <= ~DEC_Y_IN;
    RAW_IN <= 8'h11;
    repeat (3) @(posedge CORE_CLK);
    #1 `CHK("held luma", y0, DEC_Y)
    `CHK("held raw", r0, RAW_OUT)
  endtask : hold_check

  // Luma step 0 to 256 in bypass; centre output shows the boost, the one before it the clip
  task automatic hp_step(input logic [7:0] ctrl, input logic [7:0] mid);
    logic [7:0] ex [3];
    ex = '{8'h01, mid, 8'h80};
    reg_wr(`VL_OFS_CTRL, ctrl);
    for (int i = 0; i < 11; i++) begin
      smp(8'h80, 8'h80, 9'h100, (i < 6) ? 9'h000 : 9'h100, 9'h100);
      if (i >= 8) `CHK("luma step", ex[i - 8], CMP_Y)
    end
  endtask : hp_step

  // Component stage in bypass with its own settings, then the matrix
  task automatic comp_path;
    logic p0;
    reg_wr(`VL_OFS_CMP_CON, 8'h88);
    reg_wr(`VL_OFS_LUMA_BRI, 8'h10);
    reg_wr(`VL_OFS_CTRL, 8'h03);
    repeat (8) smp(8'h80, 8'h80, 9'h0C0, 9'h140, 9'h180);
    `CHK("comp luma", 8'hC0, CMP_Y)
    p0 = CMP_PHASE;
    smp(8'h80, 8'h80, 9'h0C0, 9'h140, 9'h180);
    @(posedge CORE_CLK);
    #1 `CHK("slot phase", ~p0, CMP_PHASE)
    `CHK("comp blue", 8'hC0, cb_seen)
    `CHK("comp red", 8'h60, cr_seen)
    reg_wr(`VL_OFS_CMP_CON, 8'h44);
    reg_wr(`VL_OFS_CTRL, 8'h00);
    repeat (8) smp(8'h80, 8'h80, 9'h000, 9'h000, 9'h100);
    @(posedge CORE_CLK);
    #1 `CHK("matrix luma", 8'h0E, CMP_Y)
    `CHK("matrix blue", 8'hC1, cb_seen)
    `CHK("matrix red", 8'h75, cr_seen)
  endtask : comp_path

  // Closing report and verdict
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    repeat (2) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    check_defaults();
    hp_step(8'h03, 8'h88);
    hp_step(8'h02, 8'h80);
    dec_levels();
    hold_check();
    comp_path();
    print_verdict();
  end

  // Bounded run: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    err_count++;
    print_verdict();
  end
endmodule : tb
